/* File: hw/acc_pkg.sv */
// Shared constants and types for the converter clock, rate and serial control.
// Assumes a 20 MHz system clock; the oscillator phase increments below derive from that rate.
package acc_pkg;

  // System clock and the two nominal master clock frequencies, in hertz.
  localparam longint MCLK_HZ = 20000000;
  localparam longint OSC_HZ_LINE0 = 2457600;
  localparam longint OSC_HZ_LINE1 = 2048000;

  // Phase accumulator that models the trimmed internal oscillator.
  localparam int PHASE_W = 24;
  localparam logic [PHASE_W-1:0] NCO_INC_LINE0 =
    PHASE_W'((OSC_HZ_LINE0 << PHASE_W) / MCLK_HZ);
  localparam logic [PHASE_W-1:0] NCO_INC_LINE1 =
    PHASE_W'((OSC_HZ_LINE1 << PHASE_W) / MCLK_HZ);

  // Master clock to modulator sampling clock ratio (divide by ten).
  localparam logic [3:0] MOD_DIV_LAST = 4'h9;

  // Conversion periods in modulator samples; identical for both line
  // frequencies because the sampling clock scales with the master clock.
  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] PER_CONT_4 = 18'h0_1000;
  localparam logic [CNT_W-1:0] PER_CONT_5 = 18'h0_0800;
  localparam logic [CNT_W-1:0] PER_CONT_6 = 18'h0_0400;
  localparam logic [CNT_W-1:0] PER_CONT_7 = 18'h0_0200;
  localparam logic [CNT_W-1:0] PER_SING_0 = 18'h3_C000;
  localparam logic [CNT_W-1:0] PER_SING_1 = 18'h1_8000;
  localparam logic [CNT_W-1:0] PER_SING_2 = 18'h0_C000;
  localparam logic [CNT_W-1:0] PER_SING_3 = 18'h0_6000;
  localparam logic [CNT_W-1:0] PER_SING_4 = 18'h0_4000;
  localparam logic [CNT_W-1:0] PER_SING_5 = 18'h0_2000;
  localparam logic [CNT_W-1:0] PER_SING_6 = 18'h0_1000;
  localparam logic [CNT_W-1:0] PER_SING_7 = 18'h0_0800;

  // Command byte layout.
  localparam int CMD_CONV_BIT = 7;
  localparam int CMD_KIND_HI = 6;
  localparam int CMD_ADDR_BIT = 0;
  localparam logic [2:0] RATE_RST = 3'h0;

  // Control register one field positions and reset value.
  localparam int CR1_EXT_CLK = 0;
  localparam int CR1_LINE_FREQ = 1;
  localparam int CR1_SINGLE = 2;
  localparam int CR1_IN_BUF = 3;
  localparam int CR1_UNIPOLAR = 4;
  localparam logic [7:0] CR1_RST = 8'h00;

  // Auxiliary pin register: high nibble direction, low nibble level.
  localparam int AUX_DIR_LSB = 4;
  localparam int AUX_LVL_LSB = 0;
  localparam logic [7:0] AUX_RST = 8'h00;

  localparam int RESULT_W = 20;

  typedef enum logic {
    ACC_CMD_READ = 1'b0,
    ACC_CMD_WRITE = 1'b1
  } acc_cmd_t;

  typedef enum logic [1:0] {
    ACC_FR_CMD = 2'b00,
    ACC_FR_WDATA = 2'b01,
    ACC_FR_RDATA = 2'b10,
    ACC_FR_DONE = 2'b11
  } acc_frame_t;

  typedef enum logic {
    ACC_CV_IDLE = 1'b0,
    ACC_CV_RUN = 1'b1
  } acc_conv_t;

endpackage

/* File: hw/acc_ser_if.sv */
// Event and byte stream from the serial receiver to the control core.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface acc_ser_if;
  logic sel_act;
  logic frame_start;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_stb;
  logic [7:0] byte_dat;
  logic frame_end;

  modport src (
    output sel_act,
    output frame_start,
    output sclk_rise,
    output sclk_fall,
    output byte_stb,
    output byte_dat,
    output frame_end
  );

  modport dst (
    input sel_act,
    input frame_start,
    input sclk_rise,
    input sclk_fall,
    input byte_stb,
    input byte_dat,
    input frame_end
  );
endinterface

/* File: hw/acc_ser_rx.sv */
// Serial receiver: synchronises the select, serial clock and data pins and
// assembles data bits into bytes. Assumes the serial clock stays at least
// two system clocks in each phase.
`timescale 1ns/1ps
module acc_ser_rx (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  acc_ser_if.src ser
);

  logic [2:0] sclk_s_ff;
  logic [2:0] cs_s_ff;
  logic [1:0] din_s_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic stb_ff;
  logic rise;
  logic fall;
  logic sel;

  // Stage 0 of each chain feeds only stage 1.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s_ff <= 3'h0;
      cs_s_ff <= 3'h7;
      din_s_ff <= 2'h0;
    end else begin
      sclk_s_ff <= {sclk_s_ff[1:0], sclk_pin};
      cs_s_ff <= {cs_s_ff[1:0], cs_n_pin};
      din_s_ff <= {din_s_ff[0], din_pin};
    end
  end

  assign sel = !cs_s_ff[1];
  assign rise = sel && sclk_s_ff[1] && !sclk_s_ff[2];
  assign fall = sel && !sclk_s_ff[1] && sclk_s_ff[2];

  // Data is taken on the serial clock rising edge only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      stb_ff <= 1'b0;
    end else begin
      stb_ff <= 1'b0;
      if (!sel) begin
        bit_cnt_ff <= 3'h0;
      end else if (rise) begin
        shift_ff <= {shift_ff[6:0], din_s_ff[1]};
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        stb_ff <= (bit_cnt_ff == 3'h7);
      end
    end
  end

  assign ser.sel_act = sel;
  assign ser.frame_start = sel && cs_s_ff[2];
  assign ser.frame_end = !sel && !cs_s_ff[2];
  assign ser.sclk_rise = rise;
  assign ser.sclk_fall = fall;
  assign ser.byte_stb = stb_ff;
  assign ser.byte_dat = shift_ff;

endmodule

/* File: hw/acc_ctrl.sv */
// Converter control core: master clock selection, modulator clock, rate
// decode, conversion timing, configuration bits, auxiliary pins and the
// shared ready/data output. Assumes a 20 MHz mclk and a serial clock of
// at most 5 MHz with each phase at least two mclk periods long.
//
// Function
// - Sample data pin on serial clock rise.
// - Output pin changes only on clock fall.
// - Output pin is data and low ready.
// - External mode runs from the clock pin.
// - Rates scale with external clock frequency.
// - Line bit picks oscillator frequency.
// - Sampling clock is master divided by ten.
// - Continuous codes 100..111 map to rates.
// - Single-cycle codes 000..111 map to rates.
// - Buffer bit enables analog input buffer.
// - Polarity bit selects unipolar or bipolar.
// - Four register-driven auxiliary pins.
// - Master clock runs and times control.
`timescale 1ns/1ps
module acc_ctrl #(
  parameter int RES_W = acc_pkg::RESULT_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  input wire logic ext_clk_pin,
  input wire logic [RES_W-1:0] conv_result,
  output logic rdy_dout_o,
  output logic rdy_dout_oe,
  output logic [3:0] aux_pin_o,
  output logic [3:0] aux_pin_oe,
  output logic external_clock_select,
  output logic line_freq_select,
  output logic single_conversion_mode,
  output logic input_buffer_enable,
  output logic unipolar_select,
  output logic master_tick,
  output logic mod_sample_tick,
  output logic conv_done,
  output logic conv_active,
  output logic [2:0] rate_code
);

  acc_ser_if ser ();

  acc_ser_rx u_rx (
    .mclk(mclk),
    .rst_n(rst_n),
    .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin),
    .din_pin(din_pin),
    .ser(ser)
  );

  // Configuration state.
  logic [7:0] cr1_ff;
  logic [7:0] aux_ff;
  logic [2:0] rate_ff;

  // Clock generation state.
  logic [acc_pkg::PHASE_W-1:0] phase_ff;
  logic nco_tick_ff;
  logic [2:0] ext_s_ff;
  logic ext_tick_ff;
  logic mtick_ff;
  logic [3:0] div_ff;
  logic stick_ff;

  // Conversion state.
  acc_pkg::acc_conv_t cv_ff;
  logic [acc_pkg::CNT_W-1:0] cnt_ff;
  logic [acc_pkg::CNT_W-1:0] period;
  logic done_ff;
  logic [RES_W-1:0] result_ff;
  logic ready_n_ff;

  // Frame state.
  acc_pkg::acc_frame_t fr_ff;
  acc_pkg::acc_frame_t nxt_fr;
  logic waddr_ff;
  logic [RES_W-1:0] rd_sh_ff;
  logic rd_mode_ff;
  logic rd_taken_ff;
  logic dout_ff;
  logic oe_ff;

  logic cmd_byte;
  logic wr_byte;
  logic conv_cmd;

  assign cmd_byte = ser.byte_stb && (fr_ff == acc_pkg::ACC_FR_CMD);
  assign wr_byte = ser.byte_stb && (fr_ff == acc_pkg::ACC_FR_WDATA);
  assign conv_cmd = cmd_byte && ser.byte_dat[acc_pkg::CMD_CONV_BIT];

  // Frame sequencing: a command byte, then a register data byte, the read-out
  // of the held result, or nothing after a conversion command. Extra bytes are ignored until the
  // select goes high.
  always_comb begin
    nxt_fr = fr_ff;
    if (!ser.sel_act) begin
      nxt_fr = acc_pkg::ACC_FR_CMD;
    end else if (cmd_byte) begin
      if (ser.byte_dat[acc_pkg::CMD_CONV_BIT]) begin
        nxt_fr = acc_pkg::ACC_FR_DONE;
      end else if (ser.byte_dat[acc_pkg::CMD_KIND_HI] ==
                   acc_pkg::ACC_CMD_WRITE) begin
        nxt_fr = acc_pkg::ACC_FR_WDATA;
      end else begin
        nxt_fr = acc_pkg::ACC_FR_RDATA;
      end
    end else if (wr_byte) begin
      nxt_fr = acc_pkg::ACC_FR_DONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fr_ff <= acc_pkg::ACC_FR_CMD;
    end else begin
      fr_ff <= nxt_fr;
    end
  end

  // Register writes; the rate code lives only in the command byte.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cr1_ff <= acc_pkg::CR1_RST;
      aux_ff <= acc_pkg::AUX_RST;
      waddr_ff <= 1'b0;
      rate_ff <= acc_pkg::RATE_RST;
    end else begin
      if (cmd_byte) begin
        waddr_ff <= ser.byte_dat[acc_pkg::CMD_ADDR_BIT];
      end
      if (conv_cmd) begin
        rate_ff <= ser.byte_dat[2:0];
      end
      if (wr_byte && !waddr_ff) begin
        cr1_ff <= ser.byte_dat;
      end
      if (wr_byte && waddr_ff) begin
        aux_ff <= ser.byte_dat;
      end
    end
  end

  // Internal oscillator model: a phase accumulator whose carry marks one
  // master clock period at the selected line frequency.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= '0;
      nco_tick_ff <= 1'b0;
    end else begin
      {nco_tick_ff, phase_ff} <= {1'b0, phase_ff} +
        {1'b0, cr1_ff[acc_pkg::CR1_LINE_FREQ] ?
         acc_pkg::NCO_INC_LINE1 : acc_pkg::NCO_INC_LINE0};
    end
  end

  // External master clock: synchronised, one tick per rising edge. Any
  // frequency below mclk/2 works and every rate follows it in proportion.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s_ff <= 3'h0;
      ext_tick_ff <= 1'b0;
    end else begin
      ext_s_ff <= {ext_s_ff[1:0], ext_clk_pin};
      ext_tick_ff <= ext_s_ff[1] && !ext_s_ff[2];
    end
  end

  // Selected master clock ticks pace the sampling divider and conversion timing.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mtick_ff <= 1'b0;
    end else begin
      mtick_ff <= cr1_ff[acc_pkg::CR1_EXT_CLK] ?
                  ext_tick_ff : nco_tick_ff;
    end
  end

  // Modulator sampling clock: one tick per ten master ticks.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 4'h0;
      stick_ff <= 1'b0;
    end else begin
      stick_ff <= 1'b0;
      if (mtick_ff) begin
        if (div_ff == acc_pkg::MOD_DIV_LAST) begin
          div_ff <= 4'h0;
          stick_ff <= 1'b1;
        end else begin
          div_ff <= div_ff + 4'h1;
        end
      end
    end
  end

  // Conversion length in modulator samples from mode and rate code.
  always_comb begin
    period = acc_pkg::PER_CONT_4;
    if (cr1_ff[acc_pkg::CR1_SINGLE]) begin
      unique case (rate_ff)
        3'h0: period = acc_pkg::PER_SING_0;
        3'h1: period = acc_pkg::PER_SING_1;
        3'h2: period = acc_pkg::PER_SING_2;
        3'h3: period = acc_pkg::PER_SING_3;
        3'h4: period = acc_pkg::PER_SING_4;
        3'h5: period = acc_pkg::PER_SING_5;
        3'h6: period = acc_pkg::PER_SING_6;
        3'h7: period = acc_pkg::PER_SING_7;
      endcase
    end else begin
      unique case (rate_ff)
        3'h5: period = acc_pkg::PER_CONT_5;
        3'h6: period = acc_pkg::PER_CONT_6;
        3'h7: period = acc_pkg::PER_CONT_7;
        default: period = acc_pkg::PER_CONT_4;
      endcase
    end
  end

  // Conversion timing. A new command restarts the count; single-cycle
  // mode stops after one result, continuous mode keeps going.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cv_ff <= acc_pkg::ACC_CV_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      result_ff <= '0;
    end else begin
      done_ff <= 1'b0;
      if (conv_cmd) begin
        cv_ff <= acc_pkg::ACC_CV_RUN;
        cnt_ff <= '0;
      end else if (cv_ff == acc_pkg::ACC_CV_RUN && stick_ff) begin
        if (cnt_ff == period - 18'h0_0001) begin
          cnt_ff <= '0;
          done_ff <= 1'b1;
          result_ff <= conv_result;
          if (cr1_ff[acc_pkg::CR1_SINGLE]) begin
            cv_ff <= acc_pkg::ACC_CV_IDLE;
          end
        end else begin
          cnt_ff <= cnt_ff + 18'h0_0001;
        end
      end
    end
  end

  // Ready flag: low once a result is held, high again after it has been
  // read out or a new conversion is commanded. A result landing in the
  // same cycle as the clear keeps the flag low.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ready_n_ff <= 1'b1;
    end else if (done_ff) begin
      ready_n_ff <= 1'b0;
    end else if (conv_cmd || (rd_taken_ff && ser.frame_end)) begin
      ready_n_ff <= 1'b1;
    end
  end

  // Shared output. Outside a frame the level tracks the ready flag while
  // the pin is released; inside a frame it moves only on a falling serial
  // clock, showing result bits after a read command and the flag
  // otherwise.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_sh_ff <= '0;
      rd_mode_ff <= 1'b0;
      rd_taken_ff <= 1'b0;
      dout_ff <= 1'b1;
    end else begin
      if (!ser.sel_act) begin
        rd_mode_ff <= 1'b0;
        rd_taken_ff <= 1'b0;
        dout_ff <= ready_n_ff;
      end else begin
        if (cmd_byte && !ser.byte_dat[acc_pkg::CMD_CONV_BIT] &&
            ser.byte_dat[acc_pkg::CMD_KIND_HI] == acc_pkg::ACC_CMD_READ) begin
          rd_sh_ff <= result_ff;
          rd_mode_ff <= 1'b1;
          rd_taken_ff <= 1'b1;
        end
        if (ser.sclk_fall) begin
          if (rd_mode_ff) begin
            dout_ff <= rd_sh_ff[RES_W-1];
            rd_sh_ff <= {rd_sh_ff[RES_W-2:0], 1'b0};
          end else begin
            dout_ff <= ready_n_ff;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= ser.sel_act;
    end
  end

  assign rdy_dout_o = dout_ff;
  assign rdy_dout_oe = oe_ff;
  assign aux_pin_o = aux_ff[acc_pkg::AUX_LVL_LSB +: 4];
  assign aux_pin_oe = aux_ff[acc_pkg::AUX_DIR_LSB +: 4];
  assign external_clock_select = cr1_ff[acc_pkg::CR1_EXT_CLK];
  assign line_freq_select = cr1_ff[acc_pkg::CR1_LINE_FREQ];
  assign single_conversion_mode = cr1_ff[acc_pkg::CR1_SINGLE];
  assign input_buffer_enable = cr1_ff[acc_pkg::CR1_IN_BUF];
  assign unipolar_select = cr1_ff[acc_pkg::CR1_UNIPOLAR];
  assign master_tick = mtick_ff;
  assign mod_sample_tick = stick_ff;
  assign conv_done = done_ff;
  assign conv_active = cv_ff;
  assign rate_code = rate_ff;

endmodule

/* File: verif/acc_host_model.sv */
// Serial host controller model driving select, serial clock and data.
// Assumes mclk at 20 MHz; the serial clock idles low between frames.
`timescale 1ns/1ps
module acc_host_model (
  input wire logic mclk,
  input wire logic rdy_pin,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Low phase of five cycles lets the device output settle before sampling.
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic rdy, output logic [19:0] rx);
    rx = 20'h0_0000;
    cs_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rdy = rdy_pin;
    for (int k = 0; k < n; k++) begin
      sclk <= 1'b0;
      din <= (k < 16) ? tx[15-k] : ~din;
      repeat (5) @(posedge mclk);
      if (k >= 8) rx = {rx[18:0], rdy_pin};
      sclk <= 1'b1;
      repeat (4) @(posedge mclk);
    end
    sclk <= 1'b0;
    repeat (2) @(posedge mclk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (4) @(posedge mclk);
  endtask
endmodule

/* File: verif/acc_ctrl_assertions.sv */
// Concurrent checks on the converter control top ports.
// Assumes one mclk domain with rst_n asynchronous and active low.
`timescale 1ns/1ps
module acc_ctrl_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic ext_clk_pin,
  input wire logic rdy_dout_o,
  input wire logic rdy_dout_oe,
  input wire logic external_clock_select,
  input wire logic single_conversion_mode,
  input wire logic master_tick,
  input wire logic mod_sample_tick,
  input wire logic conv_done,
  input wire logic conv_active,
  input wire logic [2:0] rate_code
);
  logic [3:0] tick_cnt_ff;
  logic [9:0] conv_cnt_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tick_cnt_ff <= 4'h0;
    else if (mod_sample_tick) tick_cnt_ff <= {3'h0, master_tick};
    else if (master_tick) tick_cnt_ff <= tick_cnt_ff + 4'h1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) conv_cnt_ff <= 10'h000;
    else if (conv_done || !conv_active) conv_cnt_ff <= 10'h000;
    else if (mod_sample_tick) conv_cnt_ff <= conv_cnt_ff + 10'h001;
  end

  chk_oe_on_select: assert property (
    !cs_n_pin [*5] |-> rdy_dout_oe) else $error("output not driven");
  chk_oe_released: assert property (
    cs_n_pin [*5] |-> !rdy_dout_oe) else $error("output not released");
  chk_ready_on_done: assert property (
    conv_done && cs_n_pin && !rdy_dout_oe |-> ##2 !rdy_dout_o)
    else $error("ready not low after done");
  chk_change_on_fall: assert property (
    $changed(rdy_dout_o) && rdy_dout_oe && !$past(conv_done)
    |-> !$past(sclk_pin)) else $error("output moved with clock high");
  chk_divide_by_ten: assert property (
    mod_sample_tick |-> tick_cnt_ff == 4'hA)
    else $error("sampling tick not every ten master ticks");
  chk_ext_tick: assert property (
    external_clock_select && $rose(ext_clk_pin) |-> ##[1:5] master_tick)
    else $error("external edge gave no master tick");
  chk_rate_in_frame: assert property (
    $changed(rate_code) |-> $past(rdy_dout_oe))
    else $error("rate changed outside a frame");
  chk_done_active: assert property (
    conv_done |-> $past(conv_active)) else $error("done while idle");
  chk_cont_rate: assert property (
    conv_done && !single_conversion_mode && rate_code == 3'h7
    |-> conv_cnt_ff inside {[511:513]}) else $error("code 7 length wrong");

  cover property (conv_done);
  cover property ($fell(rdy_dout_o) && rdy_dout_oe);
  cover property ($changed(rate_code));
endmodule

bind acc_ctrl acc_ctrl_assertions acc_ctrl_assertions_i (
  .mclk(mclk), .rst_n(rst_n), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin),
  .ext_clk_pin(ext_clk_pin), .rdy_dout_o(rdy_dout_o),
  .rdy_dout_oe(rdy_dout_oe), .external_clock_select(external_clock_select),
  .single_conversion_mode(single_conversion_mode),
  .master_tick(master_tick), .mod_sample_tick(mod_sample_tick),
  .conv_done(conv_done), .conv_active(conv_active), .rate_code(rate_code)
);

/* File: verif/acc_ctrl_tb.sv */
// Self-checking bench for the converter control top.
// Assumes the host model and checker files are compiled before this one.
`timescale 1ns/1ps
module acc_ctrl_tb;
  logic mclk, rst_n, ext_clk, ext_run, last_lvl, rdy_seen;
  logic sclk, cs_n, din, rdy_pin, rdy_o, rdy_oe;
  logic ext_sel, line_sel, single, in_buf, unipol;
  logic m_tick, s_tick, done, active;
  logic [19:0] conv_result, rx;
  logic [3:0] aux_o, aux_oe;
  logic [2:0] rate, ecnt;
  logic [7:0] v;
  int bad_count, num_checks, cyc, mt, ms;

  acc_ctrl acc_ctrl_i (.mclk(mclk), .rst_n(rst_n), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .din_pin(din), .ext_clk_pin(ext_clk),
    .conv_result(conv_result), .rdy_dout_o(rdy_o), .rdy_dout_oe(rdy_oe),
    .aux_pin_o(aux_o), .aux_pin_oe(aux_oe), .external_clock_select(ext_sel),
    .line_freq_select(line_sel), .single_conversion_mode(single),
    .input_buffer_enable(in_buf), .unipolar_select(unipol),
    .master_tick(m_tick), .mod_sample_tick(s_tick), .conv_done(done),
    .conv_active(active), .rate_code(rate));

  acc_host_model acc_host_model_i (.mclk(mclk), .rdy_pin(rdy_pin),
    .sclk(sclk), .cs_n(cs_n), .din(din));

  // No pull-up on the shared line, so a released pin shows the inverse of the last driven level.
  always @(posedge mclk) if (rdy_oe) last_lvl <= rdy_o;
  assign rdy_pin = rdy_oe ? rdy_o : ~last_lvl;

  always @(posedge mclk) begin
    if (ext_run) begin
      ecnt <= (ecnt == 3'h5) ? 3'h0 : ecnt + 3'h1;
      ext_clk <= (ecnt < 3'h3);
    end
  end

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      $display("timeout reached");
      conclude();
    end
  end

  task automatic chk(input string what, input logic [19:0] exp,
                     input logic [19:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_near(input string what, input int exp, input int got,
                          input int tol);
    num_checks++;
    if (got < exp - tol || got > exp + tol) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    acc_host_model_i.frame({cmd, dat}, 16, rdy_seen, rx);
  endtask

  task automatic count(input int n);
    mt = 0;
    ms = 0;
    repeat (n) begin
      @(posedge mclk);
      mt += m_tick;
      ms += s_tick;
    end
  endtask

  task automatic fin(input string name);
    $display("test %s done", name);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    ext_clk = 1'b0;
    ext_run = 1'b0;
    ecnt = 3'h0;
    last_lvl = 1'b1;
    conv_result = 20'hA_5C3E;
    bad_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("reset", 20'h0_0001, {2'h0, rdy_oe, aux_oe, aux_o, ext_sel, line_sel,
        single, in_buf, unipol, rate, rdy_o});
    fin("reset");
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h5A : 8'hA5;
      wr(8'h41, v);
      chk("aux", {12'h000, v}, {12'h000, aux_oe, aux_o});
    end
    wr(8'h40, 8'h0A);
    chk("ctrl", 20'h0_000A, {15'h0, unipol, in_buf, single, line_sel,
        ext_sel});
    count(5000);
    chk_near("osc line one", 512, mt, 2);
    wr(8'h40, 8'h14);
    chk("ctrl", 20'h0_0014, {15'h0, unipol, in_buf, single, line_sel,
        ext_sel});
    count(5000);
    chk_near("osc line zero", 614, mt, 2);
    fin("config");
    ext_run <= 1'b1;
    wr(8'h40, 8'h01);
    chk("ctrl", 20'h0_0001, {15'h0, unipol, in_buf, single, line_sel,
        ext_sel});
    count(6000);
    chk_near("ext ticks", 1000, mt, 2);
    chk_near("mod ticks", 100, ms, 1);
    fin("clock");
    acc_host_model_i.frame(16'h8700, 8, rdy_seen, rx);
    chk("rate", 20'h0_0007, {17'h0, rate});
    ms = 0;
    while (done !== 1'b1) begin
      @(posedge mclk);
      ms += s_tick;
    end
    chk_near("conv length", 512, ms, 2);
    repeat (4) @(posedge mclk);
    acc_host_model_i.frame(16'h0000, 28, rdy_seen, rx);
    chk("ready seen", 20'h0_0000, {19'h0, rdy_seen});
    chk("result", 20'hA_5C3E, rx);
    acc_host_model_i.frame(16'h0000, 8, rdy_seen, rx);
    chk("ready cleared", 20'h0_0001, {19'h0, rdy_seen});
    fin("conversion");
    acc_host_model_i.frame(16'h8000, 8, rdy_seen, rx);
    chk("rate", 20'h0_0000, {17'h0, rate});
    ms = 0;
    mt = 0;
    while (ms < 520) begin
      @(posedge mclk);
      ms += s_tick;
      mt += done;
    end
    chk_near("reserved early done", 0, mt, 0);
    fin("reserved");
    conclude();
  end
endmodule
